/* rtl/reset_sequencer.sv */
/*
 Reset and start-up sequencer: merges power-on, pin, watchdog and brown-out
 resets, times the start-up delay and keeps the reset-cause flags.
 Assumes clk_in runs whenever the delay is timed; the watchdog oscillator
 arrives as a plain pin and is sampled.
*/
`timescale 1ns/100ps
`include "reset_sequencer_consts.svh"

////////////////////////////////////////////////////////////////////////////////

module reset_sequencer
   import reset_sequencer_pkg::*;
#(
   parameter logic [`COUNT_WIDTH-1:0] CK_16K = `CK_COUNT_16K,
   parameter logic [`COUNT_WIDTH-1:0] CK_32K = `CK_COUNT_32K,
   parameter logic [`COUNT_WIDTH-1:0] OSC_16K = `OSC_COUNT_16K,
   parameter logic [`COUNT_WIDTH-1:0] OSC_64K = `OSC_COUNT_64K,
   parameter logic [`COUNT_WIDTH-1:0] PWRUP_EXTRA = `COUNT_WIDTH'(`PWRUP_EXTRA_CYCLES)
)
(
   input wire logic clk_in,
   input wire logic reset_in,
   input wire pin_set_type pins_in,
   input wire fuse_set_type fuses_in,
   input wire logic wake_in,
   input wire logic cause_write_in,
   input wire logic [7:0] cause_wdata_in,
   output logic core_reset_out,
   output logic io_init_out,
   output logic core_stall_out,
   output logic [12:0] reset_vector_out,
   output logic [7:0] reset_cause_out
);

   localparam logic [`PIN_CNT_WIDTH-1:0] PIN_LOW = `PIN_CNT_WIDTH'(`PIN_LOW_CYCLES);

   ////////////////////////////////////////////////////////////////////////////

   pin_set_type pins_sync;
   seq_reg_type state_reg;
   seq_reg_type state_next;
   logic load;
   logic [`COUNT_WIDTH-1:0] load_value;
   logic step;
   logic done;
   logic osc_edge;
   logic expire_edge;
   logic por_active;
   logic bod_active;
   logic any_active;
   logic [`COUNT_WIDTH-1:0] realtime_count;
   logic [`COUNT_WIDTH-1:0] clock_count;

   pin_synchronizer sync_inst (
      .clk_in(clk_in),
      .reset_in(reset_in),
      .pins_in(pins_in),
      .pins_out(pins_sync)
   );

   delay_counter counter_inst (
      .clk_in(clk_in),
      .reset_in(reset_in),
      .load_in(load),
      .load_value_in(load_value),
      .step_in(step),
      .done_out(done)
   );

   ////////////////////////////////////////////////////////////////////////////
   // start-up delay tables

   function automatic delay_class_type class_of(input logic [3:0] sel);
      delay_class_type c;
      c = CLASS_LONG;
      unique case (sel)
         4'h0, 4'h3, 4'h6, 4'hb, 4'he: c = CLASS_MEDIUM;
         4'h1, 4'h4, 4'h7, 4'hc, 4'hf: c = CLASS_SHORT;
         4'h2, 4'h5, 4'h8, 4'h9, 4'ha, 4'hd: c = CLASS_LONG;
      endcase
      return c;
   endfunction

   // level fuse steers the medium and long classes; the enable fuse alone steers the short class
   function automatic logic [`COUNT_WIDTH-1:0] realtime_of(input fuse_set_type f);
      logic [`COUNT_WIDTH-1:0] v;
      logic level_unprog;
      level_unprog = (f.brownout_level_fuse == `FUSE_UNPROGRAMMED);
      v = `OSC_COUNT_8;
      unique case (class_of(f.startup_select_fuse))
         CLASS_SHORT: begin
            if (f.brownout_enable_fuse != `FUSE_UNPROGRAMMED) begin
               v = `OSC_COUNT_32;
            end else begin
               v = `OSC_COUNT_8;
            end
         end
         CLASS_MEDIUM: v = level_unprog ? `OSC_COUNT_1K : `OSC_COUNT_4K;
         CLASS_LONG: v = level_unprog ? OSC_16K : OSC_64K;
         default: v = `OSC_COUNT_8;
      endcase
      return v;
   endfunction

   function automatic logic [`COUNT_WIDTH-1:0] clocks_of(input logic [3:0] sel);
      logic [`COUNT_WIDTH-1:0] v;
      v = `CK_COUNT_6;
      unique case (sel)
         4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7: v = `CK_COUNT_6;
         4'h8: v = CK_32K;
         4'ha, 4'hb, 4'hc: v = CK_16K;
         4'h9, 4'hd, 4'he, 4'hf: v = `CK_COUNT_1K;
      endcase
      return v;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      state_next = state_reg;
      load = 1'b0;
      load_value = `CK_COUNT_6;
      step = 1'b0;
      realtime_count = realtime_of(state_reg.fuses);
      clock_count = clocks_of(state_reg.fuses.startup_select_fuse);

      // fuses caught once after release
      if (!state_reg.fuses_taken) begin
         state_next.fuses = fuses_in;
         state_next.fuses_taken = 1'b1;
      end

      osc_edge = pins_sync.wdt_osc && !state_reg.osc_prev;
      state_next.osc_prev = pins_sync.wdt_osc;
      expire_edge = pins_sync.watchdog_expire && !state_reg.expire_prev;
      state_next.expire_prev = pins_sync.watchdog_expire;

      // pin low filter
      if (pins_sync.reset_pin_n) begin
         state_next.pin_cnt = '0;
         state_next.pin_active = 1'b0;
      end else if (state_reg.pin_cnt >= PIN_LOW - `PIN_CNT_WIDTH'(1)) begin
         state_next.pin_active = 1'b1;
      end else begin
         state_next.pin_cnt = state_reg.pin_cnt + `PIN_CNT_WIDTH'(1);
      end

      // watchdog pulse held until the next oscillator rising edge, at most one oscillator cycle
      if (osc_edge) begin
         state_next.wdt_pulse = 1'b0;
      end
      if (expire_edge && pins_sync.watchdog_enable) begin
         state_next.wdt_pulse = 1'b1;
      end

      por_active = !pins_sync.power_ok;
      bod_active = pins_sync.brownout_low &&
                   (state_reg.fuses.brownout_enable_fuse != `FUSE_UNPROGRAMMED);
      any_active = por_active || state_reg.pin_active || state_reg.wdt_pulse ||
                   bod_active || !state_reg.fuses_taken;

      // cause flags: software clear first, hardware set wins
      if (cause_write_in) begin
         state_next.cause = state_reg.cause & cause_wdata_in[3:0];
      end
      if (state_reg.wdt_pulse) begin
         state_next.cause[`CAUSE_WATCHDOG_BIT] = 1'b1;
      end
      if (bod_active) begin
         state_next.cause[`CAUSE_BROWNOUT_BIT] = 1'b1;
      end
      if (state_reg.pin_active) begin
         state_next.cause[`CAUSE_PIN_BIT] = 1'b1;
      end
      if (por_active) begin
         state_next.cause = `CAUSE_POWERUP_ONLY;
         state_next.powerup = 1'b1;
      end

      unique case (state_reg.state)
         ST_HOLD: begin
            load = 1'b1;
            state_next.wake = 1'b0;
            if (state_reg.powerup) begin
               state_next.state = ST_EXTRA;
               load_value = PWRUP_EXTRA;
            end else begin
               state_next.state = ST_REALTIME;
               load_value = realtime_count;
            end
         end
         ST_EXTRA: begin
            step = 1'b1;
            if (done) begin
               state_next.powerup = 1'b0;
               state_next.state = ST_REALTIME;
               load = 1'b1;
               load_value = realtime_count;
            end
         end
         ST_REALTIME: begin
            step = osc_edge;
            if (done) begin
               state_next.state = ST_CLOCKS;
               load = 1'b1;
               load_value = clock_count;
            end
         end
         ST_CLOCKS: begin
            step = 1'b1;
            if (done) begin
               state_next.state = ST_RUN;
               state_next.wake = 1'b0;
            end
         end
         ST_RUN: begin
            if (wake_in) begin
               state_next.state = ST_CLOCKS;
               state_next.wake = 1'b1;
               load = 1'b1;
               load_value = clock_count;
            end
         end
         default: begin
            state_next.state = ST_HOLD;
         end
      endcase

      // any active source restarts the whole delay
      if (any_active) begin
         state_next.state = ST_HOLD;
         state_next.wake = 1'b0;
         load = 1'b1;
         load_value = realtime_count;
      end

      // assertion registered one clock after any source is active, no start-up delay
      state_next.core_reset = any_active ||
                              !(state_next.state == ST_RUN || state_next.wake);
      state_next.core_stall = state_next.wake;
      if (state_next.fuses.boot_reset_select_fuse != `FUSE_UNPROGRAMMED) begin
         state_next.vector = `BOOT_START_ADDR;
      end else begin
         state_next.vector = `APP_START_ADDR;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // state register

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         state_reg <= '{
            state: ST_HOLD,
            fuses: '{startup_select_fuse: `STARTUP_SELECT_DEFAULT,
                     brownout_enable_fuse: `FUSE_UNPROGRAMMED,
                     brownout_level_fuse: `FUSE_UNPROGRAMMED,
                     boot_reset_select_fuse: `FUSE_UNPROGRAMMED},
            fuses_taken: 1'h0,
            pin_cnt: 7'h00,
            pin_active: 1'h0,
            wdt_pulse: 1'h0,
            osc_prev: 1'h0,
            expire_prev: 1'h0,
            cause: `CAUSE_RESET,
            powerup: 1'h1,
            wake: 1'h0,
            core_reset: 1'h1,
            core_stall: 1'h0,
            vector: `APP_START_ADDR
         };
      end else begin
         state_reg <= state_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs

   assign core_reset_out = state_reg.core_reset;
   assign io_init_out = state_reg.core_reset;
   assign core_stall_out = state_reg.core_stall;
   assign reset_vector_out = state_reg.vector;
   assign reset_cause_out = {4'h0, state_reg.cause};

endmodule // reset_sequencer

/* rtl/reset_sequencer_consts.svh */
/*
 Constants of the reset and start-up sequencer: timings, counts, reset values.
 Assumes the system clock runs at 200 MHz.
*/
`ifndef RESET_SEQUENCER_CONSTS_SVH
`define RESET_SEQUENCER_CONSTS_SVH

`define CLK_PERIOD_NS 5
`define PIN_LOW_NS 500
`define PIN_LOW_CYCLES ((`PIN_LOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PWRUP_EXTRA_NS 600000
`define PWRUP_EXTRA_CYCLES (`PWRUP_EXTRA_NS / `CLK_PERIOD_NS)

`define CK_COUNT_6 17'h00006
`define CK_COUNT_1K 17'h00400
`define CK_COUNT_16K 17'h04000
`define CK_COUNT_32K 17'h08000

`define OSC_COUNT_8 17'h00008
`define OSC_COUNT_32 17'h00020
`define OSC_COUNT_1K 17'h00400
`define OSC_COUNT_4K 17'h01000
`define OSC_COUNT_16K 17'h04000
`define OSC_COUNT_64K 17'h10000

`define STARTUP_SELECT_DEFAULT 4'h2
`define FUSE_UNPROGRAMMED 1'h1
`define APP_START_ADDR 13'h0000
`define BOOT_START_ADDR 13'h1f00

`define CAUSE_WATCHDOG_BIT 3
`define CAUSE_BROWNOUT_BIT 2
`define CAUSE_PIN_BIT 1
`define CAUSE_POWERUP_BIT 0
`define CAUSE_RESET 4'h0
`define CAUSE_POWERUP_ONLY 4'h1

`define SYNC_WIDTH 6
`define COUNT_WIDTH 17
`define PIN_CNT_WIDTH 7

`endif

/* rtl/reset_sequencer_pkg.sv */
/*
 Types of the reset and start-up sequencer.
 Assumes reset_sequencer_consts.svh is on the include path.
*/
`include "reset_sequencer_consts.svh"

package reset_sequencer_pkg;

   typedef enum logic [2:0] {
      ST_HOLD = 3'b000,
      ST_EXTRA = 3'b001,
      ST_REALTIME = 3'b010,
      ST_CLOCKS = 3'b011,
      ST_RUN = 3'b100
   } seq_state_type;

   typedef enum logic [1:0] {
      CLASS_SHORT = 2'b00,
      CLASS_MEDIUM = 2'b01,
      CLASS_LONG = 2'b10
   } delay_class_type;

   typedef struct packed {
      logic [3:0] startup_select_fuse;
      logic brownout_enable_fuse;
      logic brownout_level_fuse;
      logic boot_reset_select_fuse;
   } fuse_set_type;

   typedef struct packed {
      logic reset_pin_n;
      logic power_ok;
      logic brownout_low;
      logic wdt_osc;
      logic watchdog_expire;
      logic watchdog_enable;
   } pin_set_type;

   typedef struct packed {
      pin_set_type first;
      pin_set_type second;
   } sync_state_type;

   typedef struct packed {
      logic [`COUNT_WIDTH-1:0] count;
      logic done;
   } counter_state_type;

   typedef struct packed {
      seq_state_type state;
      fuse_set_type fuses;
      logic fuses_taken;
      logic [`PIN_CNT_WIDTH-1:0] pin_cnt;
      logic pin_active;
      logic wdt_pulse;
      logic osc_prev;
      logic expire_prev;
      logic [3:0] cause;
      logic powerup;
      logic wake;
      logic core_reset;
      logic core_stall;
      logic [12:0] vector;
   } seq_reg_type;

endpackage

/* rtl/pin_synchronizer.sv */
/*
 Two-stage synchronizer for the asynchronous inputs of the sequencer.
 Assumes inputs may change at any time relative to clk_in.
*/
`timescale 1ns/100ps

module pin_synchronizer
   import reset_sequencer_pkg::*;
(
   input wire logic clk_in,
   input wire logic reset_in,
   input wire pin_set_type pins_in,
   output pin_set_type pins_out
);

   sync_state_type state_reg;
   sync_state_type state_next;

   always_comb begin
      state_next = state_reg;
      state_next.first = pins_in;
      state_next.second = state_reg.first;
   end

   // reset value keeps pin and brown-out inactive, low supply reported
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         state_reg <= '{first: 6'h21, second: 6'h21};
      end else begin
         state_reg <= state_next;
      end
   end

   assign pins_out = state_reg.second;

endmodule // pin_synchronizer

/* rtl/delay_counter.sv */
/*
 Loadable down-counter with a registered done flag.
 Assumes load values are at least one.
*/
`timescale 1ns/100ps
`include "reset_sequencer_consts.svh"

module delay_counter
   import reset_sequencer_pkg::*;
(
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic load_in,
   input wire logic [`COUNT_WIDTH-1:0] load_value_in,
   input wire logic step_in,
   output logic done_out
);

   counter_state_type state_reg;
   counter_state_type state_next;

   always_comb begin
      state_next = state_reg;
      if (load_in) begin
         state_next.count = load_value_in;
      end else if (step_in && state_reg.count != '0) begin
         state_next.count = state_reg.count - `COUNT_WIDTH'(1);
      end
      state_next.done = (state_next.count == '0);
   end

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         state_reg <= '{count: 17'h00001, done: 1'h0};
      end else begin
         state_reg <= state_next;
      end
   end

   assign done_out = state_reg.done;

endmodule // delay_counter

/* dv/reset_sequencer_checker.sv */
/*
 Port checker of reset_sequencer.
 Assumes fuses_in only change while reset_in is high.
*/
`timescale 1ns/100ps

module reset_sequencer_checker
   import reset_sequencer_pkg::*;
(
   input wire logic clk_in,
   input wire logic reset_in,
   input wire pin_set_type pins_in,
   input wire fuse_set_type fuses_in,
   input wire logic core_reset_out,
   input wire logic io_init_out,
   input wire logic core_stall_out,
   input wire logic [12:0] reset_vector_out,
   input wire logic [7:0] reset_cause_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (reset_in);

   ////////////////////////////////////////////////////////////////////////////
   // cycles the pin has stayed low
   logic [7:0] low_cnt_reg;
   always_ff @(posedge clk_in) begin
      if (reset_in || pins_in.reset_pin_n) begin
         low_cnt_reg <= 8'h00;
      end else if (low_cnt_reg != 8'hff) begin
         low_cnt_reg <= low_cnt_reg + 8'h01;
      end
   end

   sequence s_power_low;
      !pins_in.power_ok [*5];
   endsequence
   sequence s_brown_low;
      (pins_in.brownout_low && !fuses_in.brownout_enable_fuse) [*4];
   endsequence

   ////////////////////////////////////////////////////////////////////////////
   a_pin_holds: assert property (low_cnt_reg >= 8'h6a |-> core_reset_out)
      else $error("pin low but core not in reset");
   a_brown_holds: assert property (s_brown_low |-> core_reset_out)
      else $error("brown-out but core not in reset");
   a_power_fail: assert property (s_power_low |-> core_reset_out && reset_cause_out == 8'h01)
      else $error("power low without reset and power-up cause");
   a_init_follows: assert property (io_init_out == core_reset_out)
      else $error("io init differs from core reset");
   a_vector_sel: assert property (!core_reset_out |->
      reset_vector_out == (fuses_in.boot_reset_select_fuse ? 13'h0000 : 13'h1f00))
      else $error("wrong start vector");
   a_stall_apart: assert property (core_stall_out |-> !core_reset_out)
      else $error("stall during reset");
   a_cause_upper: assert property (reset_cause_out[7:4] == 4'h0)
      else $error("upper cause bits set");
   a_delay_starts: assert property ($rose(pins_in.power_ok) |=> core_reset_out [*8])
      else $error("reset released too early after power-up");
   a_release_quiet: assert property ($fell(core_reset_out) |->
      $past(pins_in.power_ok, 4) && $past(pins_in.reset_pin_n, 4))
      else $error("reset released while a source active");
endmodule // reset_sequencer_checker

bind reset_sequencer reset_sequencer_checker chk_u (.clk_in(clk_in), .reset_in(reset_in),
   .pins_in(pins_in), .fuses_in(fuses_in), .core_reset_out(core_reset_out),
   .io_init_out(io_init_out), .core_stall_out(core_stall_out),
   .reset_vector_out(reset_vector_out), .reset_cause_out(reset_cause_out));

/* dv/ext_reset_source.sv */
/*
 External reset source: pulls the reset pin low for a given cycle count.
 Assumes start_in is driven by non-blocking assignment at the falling edge.
*/
`timescale 1ns/100ps

module ext_reset_source (
   input wire logic clk_in,
   input wire logic start_in,
   input wire logic [7:0] low_len_in,
   output logic reset_pin_n_out
);
   logic [7:0] left_reg = 8'h00;
   always @(negedge clk_in) begin
      if (start_in && left_reg == 8'h00) begin
         left_reg <= low_len_in;
      end else if (left_reg != 8'h00) begin
         left_reg <= left_reg - 8'h01;
      end
   end
   // pin pulled up when released
   assign reset_pin_n_out = (left_reg == 8'h00);
endmodule // ext_reset_source

/* dv/test_reset_sequencer.sv */
/*
 Testbench of reset_sequencer with shortened counts.
 Assumes the checker is bound and the pin source model is compiled.
*/
`timescale 1ns/100ps

module test_reset_sequencer
   import reset_sequencer_pkg::*;
;
   typedef struct packed {
      logic [3:0] code;
      logic lvl;
      logic en;
      logic boot;
      logic [31:0] n;
      logic [31:0] m;
   } row_type;
   localparam int P = 4;
   localparam int X = 50;
   localparam row_type ROWS [8] = '{
      '{4'h2, 1'h1, 1'h1, 1'h1, 32'h0a, 32'h06}, '{4'h0, 1'h1, 1'h1, 1'h1, 32'h400, 32'h06},
      '{4'hb, 1'h0, 1'h1, 1'h1, 32'h1000, 32'h14}, '{4'h8, 1'h0, 1'h1, 1'h0, 32'h28, 32'h1e},
      '{4'h9, 1'h1, 1'h1, 1'h1, 32'h0a, 32'h400}, '{4'ha, 1'h1, 1'h1, 1'h1, 32'h0a, 32'h14},
      '{4'hf, 1'h0, 1'h1, 1'h1, 32'h08, 32'h400}, '{4'h1, 1'h1, 1'h0, 1'h1, 32'h20, 32'h06}};

   logic clk = 1'b0;
   logic rst = 1'b1;
   logic pwr = 1'b0;
   logic bo = 1'b0;
   logic osc = 1'b0;
   logic wexp = 1'b0;
   logic wen = 1'b0;
   logic wake = 1'b0;
   logic cwr = 1'b0;
   logic pstart = 1'b0;
   logic [7:0] plen = 8'h00;
   logic [7:0] cdata = 8'h00;
   logic pin_n;
   fuse_set_type fuses = '{4'h2, 1'h1, 1'h1, 1'h1};
   pin_set_type pins;
   logic core_reset, io_init, core_stall;
   logic [12:0] vector;
   logic [7:0] cause;
   logic [31:0] k;
   int err_count = 0;
   int checks = 0;

   always #2.5 clk = ~clk;
   always #10 osc = ~osc;
   assign pins = '{pin_n, pwr, bo, osc, wexp, wen};

   ext_reset_source src_u (.clk_in(clk), .start_in(pstart), .low_len_in(plen),
      .reset_pin_n_out(pin_n));
   reset_sequencer #(.CK_16K(17'h14), .CK_32K(17'h1e), .OSC_16K(17'h0a), .OSC_64K(17'h28),
      .PWRUP_EXTRA(17'h32)) dut_u (.clk_in(clk), .reset_in(rst), .pins_in(pins),
      .fuses_in(fuses), .wake_in(wake), .cause_write_in(cwr), .cause_wdata_in(cdata),
      .core_reset_out(core_reset), .io_init_out(io_init), .core_stall_out(core_stall),
      .reset_vector_out(vector), .reset_cause_out(cause));

   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input int c);
      repeat (c) @(negedge clk);
   endtask
   task automatic wait_rel(input int lo, input int hi);
      int n;
      n = 0;
      while (core_reset !== 1'b0 && n < hi + 50) begin
         @(negedge clk);
         n++;
      end
      check({31'h0, n >= lo && n <= hi}, 32'h1);
   endtask
   task automatic pin_start(input logic [7:0] len);
      pstart <= 1'b1;
      plen <= len;
      cyc(1);
      pstart <= 1'b0;
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      #400us;
      err_count++;
      end_of_test();
   end

   initial begin
      for (int i = 0; i < 8; i++) begin
         rst = 1'b1;
         pwr = 1'b0;
         fuses = '{ROWS[i].code, ROWS[i].en, ROWS[i].lvl, ROWS[i].boot};
         cyc(8);
         check(core_reset, 32'h1);
         check(cause, 32'h0);
         rst = 1'b0;
         cyc(6);
         pwr = 1'b1;
         wait_rel(X + P * ROWS[i].n + ROWS[i].m, X + P * ROWS[i].n + ROWS[i].m + 24);
         check(vector, ROWS[i].boot ? 32'h0 : 32'h1f00);
         check(cause, 32'h01);
         $display("row %0d done", i);
      end
      pin_start(8'h3c);
      cyc(62);
      check(core_reset, 32'h0);
      cwr = 1'b1;
      cyc(1);
      cwr = 1'b0;
      cyc(2);
      check(cause, 32'h0);
      pin_start(8'h78);
      cyc(121);
      check(core_reset, 32'h1);
      wait_rel(134, 160);
      check(cause, 32'h02);
      $display("pin test done");
      wexp = 1'b1;
      cyc(4);
      wexp = 1'b0;
      cyc(10);
      check(core_reset, 32'h0);
      wen = 1'b1;
      wexp = 1'b1;
      cyc(4);
      wexp = 1'b0;
      cyc(4);
      check(core_reset, 32'h1);
      wait_rel(120, 160);
      check(cause, 32'h0a);
      $display("watchdog test done");
      bo = 1'b1;
      pin_start(8'h78);
      cyc(40);
      check(core_reset, 32'h1);
      bo = 1'b0;
      wait_rel(214, 300);
      check(cause, 32'h0e);
      $display("overlap test done");
      wake = 1'b1;
      cyc(1);
      wake = 1'b0;
      k = 32'h0;
      repeat (20) begin
         k = k + core_stall;
         @(negedge clk);
      end
      check(k, 32'h07);
      check(core_reset, 32'h0);
      $display("wake test done");
      pwr = 1'b0;
      cyc(4);
      check(core_reset, 32'h1);
      cyc(1);
      check(cause, 32'h01);
      rst = 1'b1;
      cyc(3);
      check(io_init, 32'h1);
      check(core_stall, 32'h0);
      $display("power fail test done");
      end_of_test();
   end
endmodule // test_reset_sequencer
